// ==== utf_framer.sv ====
/*
 * telemetry packet framer: collects 16-bit samples, then emits one
 * standard packet (header, data, footer) as one udp payload stream.
 * assumes samples and configuration come from the same clock domain;
 * only the strap pin is asynchronous.
 */
`timescale 1ns/1ps
module utf_framer (
    input  wire logic             CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic             ADDR_STRAP_N_I,
    input  wire logic [31:0]      PROG_IP_I,
    input  wire utf_pkg::utf_slot_t KEY_SLOT_I,
    input  wire utf_pkg::utf_word_t KEY_I,
    input  wire utf_pkg::utf_word_t END_WORD_I,
    input  wire logic [6:0]       PKT_WORDS_I,
    input  wire logic             SAMPLE_VALID_I,
    input  wire utf_pkg::utf_word_t SAMPLE_I,
    input  wire logic             TX_READY_I,
    output logic                  SAMPLE_READY_O,
    output logic                  TX_VALID_O,
    output utf_pkg::utf_word_t    TX_DATA_O,
    output logic                  TX_SOP_O,
    output logic                  TX_EOP_O,
    output logic [31:0]           DEST_IP_O,
    output logic [47:0]           TIME_US_O
);
    import utf_pkg::*;

    utf_state_t      st_q;
    utf_word_t       buf_q [MAX_WORDS];
    logic [CNT_W-1:0] wr_q;
    logic [CNT_W-1:0] rd_q;
    logic [CNT_W-1:0] len_q;
    utf_slot_t       slot_q;
    utf_word_t       key_q;
    logic [TIME_W-1:0] stamp_q;
    logic [TIME_W-1:0] us_q;
    logic [US_DIV_W-1:0] div_q;
    logic            strap_s1_q;
    logic            strap_s2_q;
    logic            take;
    logic            adv;
    logic [CNT_W-1:0] target;
    utf_word_t       word_d;

    utf_seq_if seq ();

    utf_seq_bank u_seq (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .seq     (seq.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // strap sync and address choice
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            // reset as grounded: a strapped board never shows the programmed address
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= ADDR_STRAP_N_I;
            strap_s2_q <= strap_s1_q;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DEST_IP_O <= DEFAULT_IP;
        end else begin
            DEST_IP_O <= strap_s2_q ? PROG_IP_I : DEFAULT_IP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running microsecond time base
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_q <= '0;
            us_q  <= '0;
        end else if (div_q == US_DIV_W'(US_CYCLES - 1)) begin
            div_q <= '0;
            us_q  <= us_q + 48'h0000_0000_0001;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TIME_US_O <= '0;
        end else begin
            TIME_US_O <= us_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample capture
    // zero or oversize lengths are clamped so a packet always ends
    assign target = (PKT_WORDS_I == 7'h00) ? 7'h01 :
                    (PKT_WORDS_I > 7'(MAX_WORDS)) ? 7'(MAX_WORDS) : PKT_WORDS_I;
    assign take   = SAMPLE_READY_O && SAMPLE_VALID_I;
    assign adv    = TX_VALID_O && TX_READY_I;

    always_ff @(posedge CLK_I) begin
        if (take) begin
            buf_q[wr_q[5:0]] <= SAMPLE_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stamp_q <= '0;
            slot_q  <= '0;
            key_q   <= '0;
            len_q   <= '0;
        end else if (take && wr_q == '0) begin
            stamp_q <= us_q;
            slot_q  <= KEY_SLOT_I;
            key_q   <= KEY_I;
            len_q   <= target;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packet state machine, standard variant only
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q <= ST_IDLE;
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE, ST_FILL: begin
                    if (take) begin
                        wr_q <= wr_q + 7'h01;
                        st_q <= ST_FILL;
                        if ((wr_q == '0 ? target : len_q) == wr_q + 7'h01) begin
                            st_q <= ST_KEY;
                        end
                    end
                end
                ST_KEY:  if (adv) st_q <= ST_SIZE;
                ST_SIZE: if (adv) st_q <= ST_T2;
                ST_T2:   if (adv) st_q <= ST_T1;
                ST_T1:   if (adv) st_q <= ST_T0;
                ST_T0:   if (adv) st_q <= ST_STAT;
                ST_STAT: if (adv) st_q <= ST_SEQ;
                ST_SEQ:  if (adv) st_q <= ST_DATA;
                ST_DATA: begin
                    if (adv) begin
                        rd_q <= rd_q + 7'h01;
                        if (rd_q + 7'h01 == len_q) st_q <= ST_END;
                    end
                end
                ST_END: begin
                    if (adv) begin
                        st_q <= ST_IDLE;
                        wr_q <= '0;
                        rd_q <= '0;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign seq.slot = slot_q;
    assign seq.bump = adv && (st_q == ST_END);

    ////////////////////////////////////////////////////////////////////////
    // output word selection
    always_comb begin
        case (st_q)
            ST_KEY:  word_d = key_q;
            ST_SIZE: word_d = {9'h000, len_q};
            ST_T2:   word_d = stamp_q[47:32];
            ST_T1:   word_d = stamp_q[31:16];
            ST_T0:   word_d = stamp_q[15:0];
            ST_STAT: word_d = STATUS_RSVD;
            ST_SEQ:  word_d = seq.value;
            ST_DATA: word_d = buf_q[rd_q[5:0]];
            ST_END:  word_d = END_WORD_I;
            default: word_d = '0;
        endcase
    end

    // registered stream: a word is shown one cycle after its state settles,
    // so state only advances once the registered copy is accepted
    logic        show_q;
    utf_state_t  shown_q;
    logic [CNT_W-1:0] shown_rd_q;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shown_q    <= ST_IDLE;
            shown_rd_q <= '0;
        end else begin
            shown_q    <= st_q;
            shown_rd_q <= rd_q;
        end
    end
    assign show_q = (shown_q == st_q) && (shown_rd_q == rd_q);

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TX_VALID_O     <= 1'b0;
            TX_DATA_O      <= '0;
            TX_SOP_O       <= 1'b0;
            TX_EOP_O       <= 1'b0;
            SAMPLE_READY_O <= 1'b0;
        end else begin
            // one packet is one datagram payload, framed by sop and eop
            TX_VALID_O     <= (st_q >= ST_KEY) && show_q && !adv;
            TX_DATA_O      <= word_d;
            TX_SOP_O       <= (st_q == ST_KEY);
            TX_EOP_O       <= (st_q == ST_END);
            SAMPLE_READY_O <= ((st_q == ST_IDLE) || (st_q == ST_FILL)) && !take
                              && !(st_q == ST_FILL && wr_q == len_q);
        end
    end
endmodule : utf_framer

// ==== utf_pkg.sv ====
/*
 * constants and types for the udp telemetry packet framer.
 * assumes a single 100 MHz clock domain; no software registers.
 */
package utf_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned TIME_W      = 48;
    localparam int unsigned KEY_SLOTS   = 4;
    localparam int unsigned SLOT_W      = 2;
    localparam int unsigned MAX_WORDS   = 64;
    localparam int unsigned CNT_W       = 7;
    localparam logic [31:0] DEFAULT_IP  = 32'hE000_0003;
    localparam logic [15:0] STATUS_RSVD = 16'h0000;
    localparam logic [15:0] SEQ_RESET   = 16'h0000;
    localparam logic [15:0] SEQ_STEP    = 16'h0001;
    localparam int unsigned US_NS       = 1000;
    localparam int unsigned CLK_NS      = 10;
    localparam int unsigned US_CYCLES   = US_NS / CLK_NS;
    localparam int unsigned US_DIV_W    = 7;

    typedef logic [WORD_W-1:0] utf_word_t;
    typedef logic [SLOT_W-1:0] utf_slot_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FILL, ST_KEY, ST_SIZE, ST_T2, ST_T1, ST_T0,
        ST_STAT, ST_SEQ, ST_DATA, ST_END
    } utf_state_t;
endpackage : utf_pkg

// ==== utf_seq_if.sv ====
/*
 * carrier between framer top and its sequence counter bank.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
interface utf_seq_if;
    import utf_pkg::*;
    utf_slot_t slot;
    logic      bump;
    utf_word_t value;
    modport top (output slot, output bump, input value);
    modport bank (input slot, input bump, output value);
endinterface : utf_seq_if

// ==== utf_seq_bank.sv ====
/*
 * per-key sequence counter bank.
 * assumes slot selects the key definition and bump is one-cycle pulse.
 */
`timescale 1ns/1ps
module utf_seq_bank (
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    utf_seq_if.bank    seq
);
    import utf_pkg::*;

    utf_word_t cnt_q [KEY_SLOTS];

    assign seq.value = cnt_q[seq.slot];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < KEY_SLOTS; i++) begin
                cnt_q[i] <= SEQ_RESET;
            end
        end else if (seq.bump) begin
            // natural 16-bit overflow gives the wrap to zero
            cnt_q[seq.slot] <= cnt_q[seq.slot] + SEQ_STEP;
        end
    end
endmodule : utf_seq_bank

// ==== utf_sink.sv ====
/* receiver model for the framer tx stream.
   assumes the bench reads words, n and pkts after each packet. */
`timescale 1ns/1ps
module utf_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [15:0] data_i,
    input  wire logic        sop_i,
    input  wire logic        eop_i,
    output logic             ready_o
);
    logic [15:0] words [0:79];
    int          n;
    int          pkts;
    logic [1:0]  cnt_q;
    // slow mode takes one edge in four, so the framer must hold
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 2'h0;
            ready_o <= 1'b0;
            n <= 0;
            pkts <= 0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            ready_o <= !stall_i || (cnt_q == 2'h3);
            if (valid_i && ready_o) begin
                words[sop_i ? 0 : n] <= data_i;
                n <= sop_i ? 1 : n + 1;
                if (eop_i) pkts <= pkts + 1;
            end
        end
    end
endmodule : utf_sink

// ==== utf_framer_sva.sv ====
/* assertions on the framer ports.
   assumes one clock domain and 16-bit tx words. */
`timescale 1ns/1ps
module utf_framer_sva (
    input wire logic               CLK_I,
    input wire logic               RST_N_I,
    input wire logic               ADDR_STRAP_N_I,
    input wire logic [31:0]        PROG_IP_I,
    input wire utf_pkg::utf_word_t END_WORD_I,
    input wire logic               TX_READY_I,
    input wire logic               SAMPLE_READY_O,
    input wire logic               TX_VALID_O,
    input wire utf_pkg::utf_word_t TX_DATA_O,
    input wire logic               TX_SOP_O,
    input wire logic               TX_EOP_O,
    input wire logic [31:0]        DEST_IP_O
);
    import utf_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] idx_q;
    utf_word_t  size_q;
    wire        acc = TX_VALID_O && TX_READY_I;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) idx_q <= 8'h00;
        else if (acc) idx_q <= TX_EOP_O ? 8'h00 : idx_q + 8'h01;
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) size_q <= 16'h0000;
        else if (acc && idx_q == 8'h01) size_q <= TX_DATA_O;
    end
    ////////////////////////////////////////////////////////////////////
    a_sop_at_start: assert property (
        TX_VALID_O |-> TX_SOP_O == (idx_q == 8'h00)) else $error("sop misplaced");
    a_status_word: assert property (
        TX_VALID_O && idx_q == 8'h05 |-> TX_DATA_O == 16'h0000) else $error("status");
    a_size_count: assert property (
        acc && TX_EOP_O |-> idx_q == size_q[7:0] + 8'h07) else $error("size count");
    a_end_word: assert property (
        TX_VALID_O && TX_EOP_O |-> TX_DATA_O == END_WORD_I) else $error("end word");
    a_tx_hold: assert property (
        TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
        else $error("tx word dropped");
    a_word_gap: assert property (
        acc && !TX_EOP_O |=> !TX_VALID_O ##1 !TX_VALID_O ##1 TX_VALID_O) else $error("word gap");
    a_default_ip: assert property (
        !ADDR_STRAP_N_I [*4] |-> DEST_IP_O == 32'hE000_0003) else $error("default ip");
    a_prog_ip: assert property (
        (ADDR_STRAP_N_I && $stable(PROG_IP_I)) [*4] |-> DEST_IP_O == PROG_IP_I)
        else $error("prog ip");
    a_no_take_tx: assert property (
        TX_VALID_O |-> !SAMPLE_READY_O) else $error("sample taken in packet");
endmodule : utf_framer_sva
bind utf_framer utf_framer_sva chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .ADDR_STRAP_N_I(ADDR_STRAP_N_I), .PROG_IP_I(PROG_IP_I), .END_WORD_I(END_WORD_I),
    .TX_READY_I(TX_READY_I), .SAMPLE_READY_O(SAMPLE_READY_O), .TX_VALID_O(TX_VALID_O),
    .TX_DATA_O(TX_DATA_O), .TX_SOP_O(TX_SOP_O), .TX_EOP_O(TX_EOP_O),
    .DEST_IP_O(DEST_IP_O));

// ==== udp_telemetry_packet_framer_tb_top.sv ====
/* self-checking bench for the framer: table of packets, then address strap.
   assumes utf_sink as the tx receiver and a 100 MHz clock. */
`timescale 1ns/1ps
module udp_telemetry_packet_framer_tb_top;
    import utf_pkg::*;
    typedef struct packed {
        utf_slot_t   slot;
        utf_word_t   key;
        logic [6:0]  len;
        utf_word_t   endw;
        logic        stall;
        logic [6:0]  n;
    } utf_row_t;
    // distinct key per slot 0 and 70 are clamped lengths
    utf_row_t rows [5] = '{'{2'h0, 16'h1201, 7'h03, 16'hDEAD, 1'b0, 7'h03},
        '{2'h1, 16'hABCD, 7'h01, 16'hDEAD, 1'b1, 7'h01},
        '{2'h0, 16'h1201, 7'h02, 16'hBEEF, 1'b0, 7'h02},
        '{2'h2, 16'h5555, 7'h00, 16'hBEEF, 1'b1, 7'h01},
        '{2'h3, 16'h0F0F, 7'h46, 16'hBEEF, 1'b0, 7'h40}};
    logic clk = 0, rst_n = 0, strap = 1, sv = 0, stall = 0;
    logic rdy, srdy, tv, sop, eop;
    logic [31:0] prog_ip = 32'hC0A8_0003, dest;
    utf_slot_t slot = 2'h0;
    utf_word_t key = 16'h0000, endw = 16'h0000, sd = 16'h0000, td, e;
    utf_word_t seq [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [6:0] len = 7'h00;
    logic [47:0] tus, ts;
    int mismatches = 0, check_count = 0, k, p0;
    always #5 clk = ~clk;
    utf_framer dut_u (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_STRAP_N_I(strap),
        .PROG_IP_I(prog_ip), .KEY_SLOT_I(slot), .KEY_I(key), .END_WORD_I(endw),
        .PKT_WORDS_I(len), .SAMPLE_VALID_I(sv), .SAMPLE_I(sd), .TX_READY_I(rdy),
        .SAMPLE_READY_O(srdy), .TX_VALID_O(tv), .TX_DATA_O(td), .TX_SOP_O(sop),
        .TX_EOP_O(eop), .DEST_IP_O(dest), .TIME_US_O(tus));
    utf_sink sink_u (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .valid_i(tv),
        .data_i(td), .sop_i(sop), .eop_i(eop), .ready_o(rdy));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic step(input int lim);
        @(posedge clk);
        #1 k++;
        if (k >= lim) begin
            mismatches++;
            end_of_test();
        end
    endtask : step
    task automatic send(input utf_word_t d, input bit first);
        k = 0;
        while (srdy !== 1'b1) step(200);
        sv = 1;
        sd = d;
        step(200);
        sv = 0;
        // time output lags the counter by one edge, so it now equals the stamp
        if (first) ts = tus;
    endtask : send
    ////////////////////////////////////////////////////////////////////
    task automatic run_row(input int r);
        {slot, key, len, endw, stall} = rows[r][48:7];
        p0 = sink_u.pkts;
        for (int i = 0; i < rows[r].n; i++) send(16'(r * 16 + i), i == 0);
        k = 0;
        while (sink_u.pkts == p0) step(1000);
        cmp(32'(sink_u.n), 32'(rows[r].n) + 32'd8);
        for (int j = 0; j < 8 + rows[r].n; j++) begin
            case (j)
                0: e = key;
                1: e = 16'(rows[r].n);
                2: e = ts[47:32];
                3: e = ts[31:16];
                4: e = ts[15:0];
                5: e = 16'h0000;
                6: e = seq[slot];
                default: e = (j == 7 + rows[r].n) ? endw : 16'(r * 16 + j - 7);
            endcase
            cmp(32'(sink_u.words[j]), 32'(e));
        end
        seq[slot] = seq[slot] + 16'h0001;
    endtask : run_row
    initial begin
        repeat (5) @(posedge clk);
        cmp(dest, 32'hE000_0003);
        #1 rst_n = 1;
        foreach (rows[r]) run_row(r);
        repeat (4) @(posedge clk);
        #1 cmp(dest, prog_ip);
        strap = 0;
        repeat (4) @(posedge clk);
        #1 cmp(dest, 32'hE000_0003);
        ts = tus;
        repeat (US_CYCLES) @(posedge clk);
        #1 cmp(32'(tus - ts), 32'h0000_0001);
        // mid-run reset: counters must restart from zero
        rst_n = 0;
        seq = '{default: 16'h0000};
        @(posedge clk);
        #1 cmp(32'({tv, srdy, sop, eop}), 32'h0000_0000);
        cmp(dest, 32'hE000_0003);
        cmp(32'(tus), 32'h0000_0000);
        rst_n = 1;
        run_row(0);
        end_of_test();
    end
endmodule : udp_telemetry_packet_framer_tb_top
